// file: core/wakeev_params.svh
// constants for the wake event interrupt block: offsets, field positions, reset values
// assumes inclusion by bare name from the modules
`ifndef WAKEEV_PARAMS_SVH
`define WAKEEV_PARAMS_SVH
// register byte offsets on the 32-bit bus
`define WAKEEV_OFF_SEL_HI   12'h000
`define WAKEEV_OFF_SEL_LO   12'h004
`define WAKEEV_OFF_FLG_HI   12'h008
`define WAKEEV_OFF_FLG_LO   12'h00C
`define WAKEEV_OFF_GRP_EN   12'h010
`define WAKEEV_OFF_IRQ_ST   12'h014
`define WAKEEV_OFF_IRQ_MSK  12'h018
// group enable field positions
`define WAKEEV_BIT_UP_EN    7
`define WAKEEV_BIT_LO_EN    6
// reset values
`define WAKEEV_RST_BYTE     8'h00
`define WAKEEV_RST_PIN      16'hFFFF
`define WAKEEV_RST_IRQ      2'h0
// axi response codes
`define WAKEEV_RESP_OKAY    2'h0
`define WAKEEV_RESP_SLVERR  2'h2
`endif

// file: core/wakeev_pkg.sv
// types shared by the wake event interrupt block
// assumes the params header sits beside this file
package wakeev_pkg;
   // one detected edge per wake input, upper half is inputs 15..8
   typedef struct packed {
      logic [7:0] upper;
      logic [7:0] lower;
   } wakeev_pair_t;
   // write-channel states of the bus slave
   typedef enum logic [2:0] {
      WAKEEV_W_IDLE = 3'b001,
      WAKEEV_W_EXEC = 3'b010,
      WAKEEV_W_RESP = 3'b100
   } wakeev_wst_t;
endpackage : wakeev_pkg

// file: core/wakeev_edge.sv
// edge detector for the sixteen wake inputs
// assumes pins already synchronous to mclk_i; works regardless of pin direction
`timescale 1ns/1ps
`include "wakeev_params.svh"
module wakeev_edge
   import wakeev_pkg::*;
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // pins and edge selects
   input wire logic [15:0] pin_i,
   input wire wakeev_pair_t sel_i,
   // detected edges
   output wakeev_pair_t hit_o
);
   logic [15:0] prev_r; // pin level one cycle ago
   logic [15:0] prev_nxt;
   logic [15:0] sel_w; // flat edge selects
   logic [15:0] hit_w;

   assign sel_w = {sel_i.upper, sel_i.lower};

   // **********************************
   // edge compare per input
   // **********************************
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi = gi + 1) begin : g_edge
         // 0 picks falling, 1 picks rising
         assign hit_w[gi] = sel_w[gi] ? (pin_i[gi] & ~prev_r[gi])
                                      : (~pin_i[gi] & prev_r[gi]);
      end
   endgenerate

   // previous level simply follows the pin, independent of port direction
   always_comb begin
      prev_nxt = pin_i;
   end

   // idle-high reset matches the idle level of the active-low sources, so no false
   // edge follows release; a pin already low at release does count as a fall
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         prev_r <= `WAKEEV_RST_PIN;
      end else begin
         prev_r <= prev_nxt;
      end
   end

   assign hit_o = '{upper: hit_w[15:8], lower: hit_w[7:0]};
endmodule : wakeev_edge

// file: core/wakeev_top.sv
// wake event interrupt block: sixteen edge-sensed wake inputs in two groups of eight
// assumes an AXI4-Lite master on mclk_i and pins synchronous to mclk_i
// Operation
// - select bit: 0 falling, 1 rising edge
// - selected edge sets the input's request flag
// - flag clears on write 0 after read 1
// - writing 1 leaves flag; software never sets
// - enable bit 7 gates upper group request
// - enable bit 6 gates lower group request
// - enable bits 5..0 reserved, read zero
// - one shared request per group of eight
// - detection works whatever the pin direction
//
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "wakeev_params.svh"
module wakeev_top
   import wakeev_pkg::*;
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // wake pins, active low sources
   input wire logic [15:0] wake_input_pin_i,
   // axi4-lite write address
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // group requests to the interrupt controller
   output logic upper_irq_o,
   output logic lower_irq_o,
   // combined interrupt from status and mask
   output logic irq_o
);

   // ******************************************
   // register state
   // ******************************************
   wakeev_pair_t sel_r, sel_nxt; // edge select bits
   wakeev_pair_t flg_r, flg_nxt; // request flags
   wakeev_pair_t armed_r, armed_nxt; // flag seen as 1 by a read
   logic [1:0] grp_en_r, grp_en_nxt; // [1] upper, [0] lower
   logic [1:0] ist_r, ist_nxt; // sticky interrupt status
   logic [1:0] imsk_r, imsk_nxt; // interrupt mask, 1 passes
   wakeev_pair_t hit_w; // edges this cycle
   logic upper_req_w, lower_req_w;

   // bus slave state
   wakeev_wst_t wst_r, wst_nxt;
   logic [11:0] waddr_r, waddr_nxt;
   logic [31:0] wdata_r, wdata_nxt;
   logic [3:0] wstrb_r, wstrb_nxt;
   logic aw_got_r, aw_got_nxt; // address taken
   logic w_got_r, w_got_nxt; // data taken
   logic [1:0] bresp_r, bresp_nxt;
   logic rvalid_r, rvalid_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [1:0] rresp_r, rresp_nxt;
   logic wr_do_w; // write commits this cycle
   logic rd_do_w; // read is accepted this cycle
   logic [31:0] rd_val_w; // read mux result
   logic rd_ok_w;

   // ******************************************
   // edge detection
   // ******************************************
   wakeev_edge u_edge (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .pin_i(wake_input_pin_i),
      .sel_i(sel_r),
      .hit_o(hit_w)
   );

   // ******************************************
   // write channel: either order, one write at a time
   // ******************************************
   assign s_axi_awready = (wst_r == WAKEEV_W_IDLE) && !aw_got_r;
   assign s_axi_wready = (wst_r == WAKEEV_W_IDLE) && !w_got_r;
   assign wr_do_w = (wst_r == WAKEEV_W_EXEC);

   // collect address and data, then commit, then respond
   always_comb begin
      wst_nxt = wst_r;
      waddr_nxt = waddr_r;
      wdata_nxt = wdata_r;
      wstrb_nxt = wstrb_r;
      aw_got_nxt = aw_got_r;
      w_got_nxt = w_got_r;
      bresp_nxt = bresp_r;
      unique case (wst_r)
         WAKEEV_W_IDLE: begin
            if (s_axi_awvalid && s_axi_awready) begin
               waddr_nxt = s_axi_awaddr;
               aw_got_nxt = 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
               wdata_nxt = s_axi_wdata;
               wstrb_nxt = s_axi_wstrb;
               w_got_nxt = 1'b1;
            end
            if (aw_got_nxt && w_got_nxt) begin
               wst_nxt = WAKEEV_W_EXEC;
            end
         end
         WAKEEV_W_EXEC: begin
            // unmapped addresses answer with slave error
            bresp_nxt = (waddr_r[11:2] <= `WAKEEV_OFF_IRQ_MSK >> 2) ? `WAKEEV_RESP_OKAY
                                                                 : `WAKEEV_RESP_SLVERR;
            wst_nxt = WAKEEV_W_RESP;
         end
         WAKEEV_W_RESP: begin
            if (s_axi_bready) begin
               aw_got_nxt = 1'b0;
               w_got_nxt = 1'b0;
               wst_nxt = WAKEEV_W_IDLE;
            end
         end
         default: begin
            wst_nxt = WAKEEV_W_IDLE;
         end
      endcase
   end

   assign s_axi_bvalid = (wst_r == WAKEEV_W_RESP);
   assign s_axi_bresp = bresp_r;

   // ******************************************
   // read channel: one beat, answered the cycle after the address
   // ******************************************
   assign s_axi_arready = !rvalid_r;
   assign rd_do_w = s_axi_arvalid && s_axi_arready;

   // read mux; reserved and upper bits read as zero
   always_comb begin
      rd_val_w = 32'h0000_0000;
      rd_ok_w = 1'b1;
      unique case ({s_axi_araddr[11:2], 2'b00})
         `WAKEEV_OFF_SEL_HI: rd_val_w[7:0] = sel_r.upper;
         `WAKEEV_OFF_SEL_LO: rd_val_w[7:0] = sel_r.lower;
         `WAKEEV_OFF_FLG_HI: rd_val_w[7:0] = flg_r.upper;
         `WAKEEV_OFF_FLG_LO: rd_val_w[7:0] = flg_r.lower;
         `WAKEEV_OFF_GRP_EN: begin
            rd_val_w[`WAKEEV_BIT_UP_EN] = grp_en_r[1];
            rd_val_w[`WAKEEV_BIT_LO_EN] = grp_en_r[0];
         end
         `WAKEEV_OFF_IRQ_ST: rd_val_w[1:0] = ist_r;
         `WAKEEV_OFF_IRQ_MSK: rd_val_w[1:0] = imsk_r;
         default: rd_ok_w = 1'b0;
      endcase
   end

   // hold read data until the master takes it
   always_comb begin
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      if (rvalid_r && s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end
      if (rd_do_w) begin
         rvalid_nxt = 1'b1;
         rdata_nxt = rd_val_w;
         rresp_nxt = rd_ok_w ? `WAKEEV_RESP_OKAY : `WAKEEV_RESP_SLVERR;
      end
   end

   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   // ******************************************
   // control registers and request flags
   // ******************************************
   always_comb begin
      sel_nxt = sel_r;
      grp_en_nxt = grp_en_r;
      imsk_nxt = imsk_r;
      flg_nxt = flg_r;
      armed_nxt = armed_r;
      if (wr_do_w && wstrb_r[0]) begin
         unique case ({waddr_r[11:2], 2'b00})
            `WAKEEV_OFF_SEL_HI: sel_nxt.upper = wdata_r[7:0];
            `WAKEEV_OFF_SEL_LO: sel_nxt.lower = wdata_r[7:0];
            // only a 0 on an armed bit clears; a 1 leaves the flag as is
            `WAKEEV_OFF_FLG_HI: begin
               flg_nxt.upper = flg_r.upper & ~(armed_r.upper & ~wdata_r[7:0]);
               armed_nxt.upper = armed_r.upper & wdata_r[7:0];
            end
            `WAKEEV_OFF_FLG_LO: begin
               flg_nxt.lower = flg_r.lower & ~(armed_r.lower & ~wdata_r[7:0]);
               armed_nxt.lower = armed_r.lower & wdata_r[7:0];
            end
            // reserved bits 5..0 are not stored
            `WAKEEV_OFF_GRP_EN: begin
               grp_en_nxt = {wdata_r[`WAKEEV_BIT_UP_EN], wdata_r[`WAKEEV_BIT_LO_EN]};
            end
            `WAKEEV_OFF_IRQ_MSK: imsk_nxt = wdata_r[1:0];
            default: begin
            end
         endcase
      end
      // a read of a flag register arms the bits it saw set; done after the write so a
      // write in the same cycle cannot drop the arming, and a bit it cleared stays unarmed
      if (rd_do_w && ({s_axi_araddr[11:2], 2'b00} == `WAKEEV_OFF_FLG_HI)) begin
         armed_nxt.upper = armed_nxt.upper | (flg_r.upper & flg_nxt.upper);
      end
      if (rd_do_w && ({s_axi_araddr[11:2], 2'b00} == `WAKEEV_OFF_FLG_LO)) begin
         armed_nxt.lower = armed_nxt.lower | (flg_r.lower & flg_nxt.lower);
      end
      // edges win over a clear in the same cycle
      flg_nxt.upper = flg_nxt.upper | hit_w.upper;
      flg_nxt.lower = flg_nxt.lower | hit_w.lower;
   end

   // ******************************************
   // group requests and sticky interrupt status
   // ******************************************
   assign upper_req_w = (|flg_r.upper) & grp_en_r[1];
   assign lower_req_w = (|flg_r.lower) & grp_en_r[0];

   // status bits set by group requests, cleared by writing 1; set wins
   always_comb begin
      ist_nxt = ist_r;
      if (wr_do_w && wstrb_r[0] && ({waddr_r[11:2], 2'b00} == `WAKEEV_OFF_IRQ_ST)) begin
         ist_nxt = ist_r & ~wdata_r[1:0];
      end
      ist_nxt = ist_nxt | {upper_req_w, lower_req_w};
   end

   // ******************************************
   // state registers
   // ******************************************
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sel_r <= '{upper: `WAKEEV_RST_BYTE, lower: `WAKEEV_RST_BYTE};
         flg_r <= '{upper: `WAKEEV_RST_BYTE, lower: `WAKEEV_RST_BYTE};
         armed_r <= '{upper: `WAKEEV_RST_BYTE, lower: `WAKEEV_RST_BYTE};
         grp_en_r <= `WAKEEV_RST_IRQ;
         ist_r <= `WAKEEV_RST_IRQ;
         imsk_r <= `WAKEEV_RST_IRQ;
         wst_r <= WAKEEV_W_IDLE;
         waddr_r <= 12'h000;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         bresp_r <= `WAKEEV_RESP_OKAY;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= `WAKEEV_RESP_OKAY;
         upper_irq_o <= 1'b0;
         lower_irq_o <= 1'b0;
         irq_o <= 1'b0;
      end else begin
         sel_r <= sel_nxt;
         flg_r <= flg_nxt;
         armed_r <= armed_nxt;
         grp_en_r <= grp_en_nxt;
         ist_r <= ist_nxt;
         imsk_r <= imsk_nxt;
         wst_r <= wst_nxt;
         waddr_r <= waddr_nxt;
         wdata_r <= wdata_nxt;
         wstrb_r <= wstrb_nxt;
         aw_got_r <= aw_got_nxt;
         w_got_r <= w_got_nxt;
         bresp_r <= bresp_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
         upper_irq_o <= upper_req_w;
         lower_irq_o <= lower_req_w;
         irq_o <= |(ist_nxt & imsk_nxt);
      end
   end
endmodule : wakeev_top

// file: test/wakeev_src_model.sv
// wake source model: sixteen pin levels driven from the clock
// assumes the bench calls drive() between edges of mclk_i
`timescale 1ns/1ps
module wakeev_src_model (
   // clock
   input wire logic mclk_i,
   // pin levels
   output logic [15:0] pin_o
);
   // sources are active low, so pins idle high
   initial pin_o = 16'hFFFF;
   // new level lands just after an edge; pin direction plays no part
   task automatic drive(input logic [15:0] v);
      @(posedge mclk_i);
      pin_o <= v;
   endtask : drive
endmodule : wakeev_src_model

// file: test/wakeev_assertions.sv
// port checks for wakeev_top: bus timing and group request causes
// assumes one clock domain and the async active-low reset
`timescale 1ns/1ps
module wakeev_assertions (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // pins and bus
   input wire logic [15:0] wake_input_pin_i,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // requests
   input wire logic upper_irq_o,
   input wire logic lower_irq_o,
   input wire logic irq_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);
   // cycles since the last write data beat, saturating so it never wraps
   logic [2:0] wr_age_r;
   logic [2:0] wr_age_nxt;
   // next age
   always_comb begin
      wr_age_nxt = (wr_age_r == 3'h7) ? wr_age_r : wr_age_r + 3'h1;
      if (s_axi_wvalid && s_axi_wready) wr_age_nxt = 3'h0;
   end
   // age register
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) wr_age_r <= 3'h7;
      else wr_age_r <= wr_age_nxt;
   end
   property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
   a_bhold: assert property (p_bhold) else $error("write response dropped");
   property p_bwhen;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid;
   endproperty
   a_bwhen: assert property (p_bwhen) else $error("write response timing");
   property p_rwhen; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_rwhen: assert property (p_rwhen) else $error("read response timing");
   property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   a_rhold: assert property (p_rhold) else $error("read data not held");
   property p_arblk; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_arblk: assert property (p_arblk) else $error("read address taken while busy");
   property p_rwidth; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
   a_rwidth: assert property (p_rwidth) else $error("upper read bits set");
   property p_upfall; $fell(upper_irq_o) |-> wr_age_r <= 3'h4; endproperty
   a_upfall: assert property (p_upfall) else $error("upper request fell unasked");
   property p_lofall; $fell(lower_irq_o) |-> wr_age_r <= 3'h4; endproperty
   a_lofall: assert property (p_lofall) else $error("lower request fell unasked");
   property p_uprise;
      $rose(upper_irq_o) |-> $past(wake_input_pin_i, 2) != $past(wake_input_pin_i, 3) || wr_age_r <= 3'h4;
   endproperty
   a_uprise: assert property (p_uprise) else $error("upper request without cause");
   property p_irqfall; $fell(irq_o) |-> wr_age_r <= 3'h4; endproperty
   a_irqfall: assert property (p_irqfall) else $error("interrupt fell unasked");
endmodule : wakeev_assertions
bind wakeev_top wakeev_assertions wakeev_assertions_inst (.mclk_i, .rst_b_i, .wake_input_pin_i,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
   .upper_irq_o, .lower_irq_o, .irq_o);

// file: test/wakeev_tb_top.sv
// self-checking bench for wakeev_top against a behavioural register model
// assumes the params header on the include path
`timescale 1ns/1ps
`include "wakeev_params.svh"
module wakeev_tb_top;
   logic mclk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [15:0] wake_input_pin_i;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic upper_irq_o, lower_irq_o, irq_o;
   // model state: index 1 upper group, 0 lower group
   logic [7:0] sel [2] = '{8'h00, 8'h00};
   logic [7:0] flg [2] = '{8'h00, 8'h00};
   logic [7:0] arm [2] = '{8'h00, 8'h00};
   logic [7:0] en = 8'h00;
   logic [1:0] st = 2'h0;
   logic [1:0] msk = 2'h0;
   logic [15:0] pv = 16'hFFFF;
   logic [31:0] rs = 32'h0000005A;
   logic [31:0] r;
   int num_errors = 0;
   int n_checks = 0;
   always #2 mclk_i = ~mclk_i;
   wakeev_top wakeev_top_inst (.mclk_i, .rst_b_i, .wake_input_pin_i, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .upper_irq_o, .lower_irq_o, .irq_o);
   wakeev_src_model wakeev_src_model_inst (.mclk_i(mclk_i), .pin_o(wake_input_pin_i));
   // ****************************************
   // model helpers and bus tasks
   // ****************************************
   function automatic logic [31:0] xs();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction : xs
   // status bits are re-set while a group request stands
   function automatic void settle();
      st |= {|flg[1] & en[7], |flg[0] & en[6]};
   endfunction : settle
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   // write one register and update the model first
   task automatic put(input logic [11:0] a, input logic [7:0] d);
      logic [1:0] er;
      logic ad, wd;
      int g;
      er = `WAKEEV_RESP_OKAY;
      g = (a == `WAKEEV_OFF_FLG_HI);
      ad = 1'b0;
      wd = 1'b0;
      case (a)
         `WAKEEV_OFF_SEL_HI: sel[1] = d;
         `WAKEEV_OFF_SEL_LO: sel[0] = d;
         `WAKEEV_OFF_FLG_HI, `WAKEEV_OFF_FLG_LO: begin
            flg[g] &= ~(arm[g] & ~d);
            arm[g] &= d;
         end
         `WAKEEV_OFF_GRP_EN: en = d & 8'hC0;
         `WAKEEV_OFF_IRQ_ST: st &= ~d[1:0];
         `WAKEEV_OFF_IRQ_MSK: msk = d[1:0];
         default: er = `WAKEEV_RESP_SLVERR;
      endcase
      settle();
      @(posedge mclk_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge mclk_i);
         ad |= s_axi_awready;
         wd |= s_axi_wready;
         if (ad) s_axi_awvalid <= 1'b0;
         if (wd) s_axi_wvalid <= 1'b0;
      end while (!(ad && wd));
      do @(posedge mclk_i); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk({30'h0, s_axi_bresp}, {30'h0, er});
   endtask : put
   // read one register; a flag read arms the bits seen set
   task automatic get(input logic [11:0] a);
      logic [31:0] e;
      logic [1:0] er;
      e = 32'h0;
      er = `WAKEEV_RESP_OKAY;
      case (a)
         `WAKEEV_OFF_SEL_HI: e[7:0] = sel[1];
         `WAKEEV_OFF_SEL_LO: e[7:0] = sel[0];
         `WAKEEV_OFF_FLG_HI: e[7:0] = flg[1];
         `WAKEEV_OFF_FLG_LO: e[7:0] = flg[0];
         `WAKEEV_OFF_GRP_EN: e[7:0] = en;
         `WAKEEV_OFF_IRQ_ST: e[1:0] = st;
         `WAKEEV_OFF_IRQ_MSK: e[1:0] = msk;
         default: er = `WAKEEV_RESP_SLVERR;
      endcase
      @(posedge mclk_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge mclk_i); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge mclk_i); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, e);
      chk({30'h0, s_axi_rresp}, {30'h0, er});
      if (a == `WAKEEV_OFF_FLG_HI) arm[1] |= flg[1];
      if (a == `WAKEEV_OFF_FLG_LO) arm[0] |= flg[0];
   endtask : get
   // compare the three request outputs once they have settled
   task automatic irqs();
      settle();
      repeat (4) @(posedge mclk_i);
      chk({29'h0, upper_irq_o, lower_irq_o, irq_o},
         {29'h0, |flg[1] & en[7], |flg[0] & en[6], |(st & msk)});
   endtask : irqs
   // new pin levels: selected edges set flags
   task automatic pin(input logic [15:0] v);
      logic [15:0] s, e;
      s = {sel[1], sel[0]};
      e = (s & ~pv & v) | (~s & pv & ~v);
      flg[1] |= e[15:8];
      flg[0] |= e[7:0];
      pv = v;
      wakeev_src_model_inst.drive(v);
      irqs();
   endtask : pin
   task automatic finish_test();
      if (num_errors == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : finish_test
   // ****************************************
   // main sequence and watchdog
   // ****************************************
   initial begin
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hF;
      repeat (5) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      for (int a = 0; a <= 32; a += 4) get(a[11:0]);
      put(12'h01C, 8'hFF);
      // software keeps the reserved enable bits at their reset value of zero
      put(`WAKEEV_OFF_GRP_EN, 8'hC0);
      get(`WAKEEV_OFF_GRP_EN);
      for (int i = 0; i < 60; i++) begin
         r = xs();
         case (i % 6)
            0: begin
               put(`WAKEEV_OFF_SEL_HI, r[7:0]);
               put(`WAKEEV_OFF_SEL_LO, r[15:8]);
            end
            1: put(`WAKEEV_OFF_GRP_EN, r[7:0] & 8'hC0);
            2, 3: pin(r[15:0]);
            4: begin
               put(`WAKEEV_OFF_FLG_LO, 8'h00);
               get(`WAKEEV_OFF_FLG_HI);
               get(`WAKEEV_OFF_FLG_LO);
               put(`WAKEEV_OFF_FLG_HI, r[7:0]);
               put(`WAKEEV_OFF_FLG_LO, r[15:8]);
            end
            default: begin
               put(`WAKEEV_OFF_IRQ_ST, r[7:0]);
               put(`WAKEEV_OFF_IRQ_MSK, r[15:8]);
            end
         endcase
         irqs();
         get(`WAKEEV_OFF_IRQ_ST);
      end
      finish_test();
   end
   // a hang stops the run well past the thousand or so cycles needed
   initial begin
      #100000;
      num_errors++;
      finish_test();
   end
endmodule : wakeev_tb_top
